// ---- pms_pkg.sv ----
// constants, register map and state layout of the program-memory strap latch
// assumes a single 50 MHz clock domain and an axi4-lite register port
`default_nettype none

package pms_pkg;

	// register map, byte addresses of aligned 32-bit words
	localparam logic [3:0] PMS_CTRL_OFS   = 4'h0;
	localparam logic [3:0] PMS_STATUS_OFS = 4'h4;

	// control register fields
	localparam int         PMS_CTRL_PULLUP_BIT = 0;
	localparam logic       PMS_CTRL_RESET      = 1'b1;

	// status register field positions
	localparam int PMS_ST_STRAP_LSB   = 0;
	localparam int PMS_ST_EXT_CLK_BIT = 3;
	localparam int PMS_ST_F48_BIT     = 4;
	localparam int PMS_ST_RSVD_BIT    = 5;
	localparam int PMS_ST_SAMPLE_BIT  = 6;
	localparam int PMS_ST_FLOAT_BIT   = 7;

	// strap decode values
	localparam logic [1:0] PMS_FREQ_24  = 2'h0;
	localparam logic [1:0] PMS_FREQ_48  = 2'h3;
	localparam logic [2:0] PMS_STRAP_RESET = 3'h0;

	// axi4-lite responses
	localparam logic [1:0] PMS_RESP_OKAY   = 2'h0;
	localparam logic [1:0] PMS_RESP_SLVERR = 2'h2;

	// strap phase: pins are straps while the chip is held, address lines afterwards
	typedef enum logic [0:0]
	{
		PMS_PH_STRAP = 1'b0,
		PMS_PH_RUN   = 1'b1
	} pms_phase_t;

	// all state of the strap latch
	typedef struct packed
	{
		logic [1:0]  rst_sync;
		logic [2:0]  strap_s1;
		logic [2:0]  strap_s2;
		pms_phase_t  phase;
		logic [2:0]  strap;
		logic [15:0] addr;
		logic [2:0]  low_oe;
		logic        pullup_en;
		logic        aw_got;
		logic [3:0]  aw_addr;
		logic        w_got;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} pms_state_t;

endpackage

`default_nettype wire

// ---- pms_strap_latch.sv ----
// program-memory address pins that double as reset-time clock straps
// assumes the core address comes from clk_i logic and the pins from outside
//
// Function
// - data pins get software-controlled weak pull-ups
// - drive address bits fifteen to three
// - bit two is address outside reset
// - bit two is clock-drive strap, pulled down
// - latch bit-two strap at reset release
// - drop bit-two pull-down after release
// - drive strap 0 crystal, 1 external clock
// - drive strap 1 floats bit two in sleep
// - drive strap 0 keeps bit two driven
// - bits one, zero are frequency straps, pulled down
// - latch frequency straps at reset release
// - drop frequency pull-downs after release
// - 00 is 24MHz, 11 is 48MHz with external clock only, others reserved
// - frequency strap 1 floats its pin in sleep
// - frequency strap 0 keeps its pin driven
// - sample straps during reset, use release value
`timescale 1ns/1ps
`default_nettype none

module pms_strap_latch
	import pms_pkg::*;
(
	// clock and logic reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// chip reset pin, asynchronous to clk_i
	input  wire logic        chip_reset_n_i,
	// core side
	input  wire logic [15:0] cpu_addr_i,
	input  wire logic        idle_flag_i,
	input  wire logic        sleep_flag_i,
	input  wire logic        second_interrupt_input_i,
	// memory address pins
	output logic [12:0]      upper_code_addr_o,
	input  wire logic        code_addr_bit2_i,
	output logic             code_addr_bit2_o,
	output logic             code_addr_bit2_oe_o,
	input  wire logic [1:0]  code_addr_low_pair_i,
	output logic [1:0]       code_addr_low_pair_o,
	output logic [1:0]       code_addr_low_pair_oe_o,
	// pad resistor controls
	output logic [2:0]       strap_pulldown_en_o,
	output logic             code_data_bus_pullup_en_o,
	// decoded clock selection
	output logic             clock_drive_strap_o,
	output logic             clk_freq_48_o,
	output logic             clk_freq_reserved_o,
	// axi4-lite write address and data
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// axi4-lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// axi4-lite read
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [3:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp
);

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// word decode shared by both bus directions
	function automatic logic pms_is_ctrl(input logic [3:0] a);
		pms_is_ctrl = (a[3:2] == PMS_CTRL_OFS[3:2]);
	endfunction

	function automatic logic pms_is_status(input logic [3:0] a);
		pms_is_status = (a[3:2] == PMS_STATUS_OFS[3:2]);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// state

	// one record holds every flop so reset and update stay in one place
	pms_state_t st_r;
	pms_state_t st_nxt;

	// helpers read only registered state or same-clock core inputs
	logic       float_cond;
	logic       ext_clk;
	logic       f48;
	logic       f_rsvd;
	logic       wr_fire;
	logic [31:0] status_word;

	// sleep condition: idle, wake interrupt negated, sleep flag set
	// only acted on in the run phase; while strapping the pins are inputs
	assign float_cond = idle_flag_i & ~second_interrupt_input_i & sleep_flag_i;

	// strap decode; crystal mode only ever runs at 24 MHz
	assign ext_clk = st_r.strap[2];
	assign f48     = ext_clk & (st_r.strap[1:0] == PMS_FREQ_48);
	assign f_rsvd  = (st_r.strap[1:0] != PMS_FREQ_24)
	               & (st_r.strap[1:0] != PMS_FREQ_48);

	// status word seen by software
	// the float bit shows the live condition, not a latched event
	always_comb
	begin
		status_word = 32'h0000_0000;
		status_word[PMS_ST_STRAP_LSB +: 3] = st_r.strap;
		status_word[PMS_ST_EXT_CLK_BIT]    = ext_clk;
		status_word[PMS_ST_F48_BIT]        = f48;
		status_word[PMS_ST_RSVD_BIT]       = f_rsvd;
		status_word[PMS_ST_SAMPLE_BIT]     = (st_r.phase == PMS_PH_STRAP);
		status_word[PMS_ST_FLOAT_BIT]      = (st_r.phase == PMS_PH_RUN) & float_cond;
	end

	// both halves of a write are held before it is carried out
	assign wr_fire = st_r.aw_got & st_r.w_got & ~st_r.bvalid;

	////////////////////////////////////////////////////////////////////////////
	// next-state logic

	always_comb
	begin
		st_nxt = st_r;

		// two-flop synchronisers; stage one feeds only stage two
		// straps and chip reset share the same delay, so a strap sample and
		// the reset level beside it were taken at the same instant
		st_nxt.rst_sync = {st_r.rst_sync[0], chip_reset_n_i};
		st_nxt.strap_s1 = {code_addr_bit2_i, code_addr_low_pair_i};
		st_nxt.strap_s2 = st_r.strap_s1;

		// strap phase follows the synchronised chip reset
		unique case (st_r.phase)
			PMS_PH_STRAP:
			begin
				// refresh only while the paired reset sample is still low; the
				// board may let go of a strap as soon as the chip reset pin rises
				if (st_r.rst_sync[1])
				begin
					st_nxt.phase = PMS_PH_RUN;
				end
				else
				begin
					st_nxt.strap = st_r.strap_s2;
				end
			end
			PMS_PH_RUN:
			begin
				if (!st_r.rst_sync[1])
				begin
					st_nxt.phase = PMS_PH_STRAP;
				end
			end
		endcase

		// address register; all sixteen bits track the core
		// upper pins stay driven through chip reset, only the strap pins turn round
		st_nxt.addr = cpu_addr_i;

		// low pins: inputs while strapping, else driven unless floated
		if (st_nxt.phase == PMS_PH_STRAP)
		begin
			st_nxt.low_oe = 3'h0;
		end
		else
		begin
			// a strap of 1 floats its pin in sleep, a 0 always drives
			st_nxt.low_oe = ~(st_nxt.strap & {3{float_cond}});
		end

		// write address channel
		// a second write is held off until the response has been taken
		if (s_axi_awvalid && !st_r.aw_got && !st_r.bvalid)
		begin
			st_nxt.aw_got  = 1'b1;
			st_nxt.aw_addr = s_axi_awaddr;
		end

		// write data channel
		if (s_axi_wvalid && !st_r.w_got && !st_r.bvalid)
		begin
			st_nxt.w_got  = 1'b1;
			st_nxt.w_data = s_axi_wdata;
			st_nxt.w_strb = s_axi_wstrb;
		end

		// carry out a write once both halves are in
		if (wr_fire)
		begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got  = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp  = PMS_RESP_OKAY;
			if (pms_is_ctrl(st_r.aw_addr))
			begin
				if (st_r.w_strb[0])
				begin
					st_nxt.pullup_en = st_r.w_data[PMS_CTRL_PULLUP_BIT];
				end
			end
			else if (!pms_is_status(st_r.aw_addr))
			begin
				st_nxt.bresp = PMS_RESP_SLVERR;
			end
		end

		// write response
		if (st_r.bvalid && s_axi_bready)
		begin
			st_nxt.bvalid = 1'b0;
		end

		// read channel; status writes are ignored but acknowledged
		// unmapped words answer with an error and read as zero
		if (s_axi_arvalid && !st_r.rvalid)
		begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp  = PMS_RESP_OKAY;
			st_nxt.rdata  = 32'h0000_0000;
			if (pms_is_ctrl(s_axi_araddr))
			begin
				st_nxt.rdata[PMS_CTRL_PULLUP_BIT] = st_r.pullup_en;
			end
			else if (pms_is_status(s_axi_araddr))
			begin
				st_nxt.rdata = status_word;
			end
			else
			begin
				st_nxt.rresp = PMS_RESP_SLVERR;
			end
		end
		else if (st_r.rvalid && s_axi_rready)
		begin
			st_nxt.rvalid = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	// reset assumes the chip is in reset: straps sampled, pins released
	// a logic reset alone re-enters strapping until the chip pin is seen high
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_r           <= '0;
			st_r.phase     <= PMS_PH_STRAP;
			st_r.strap     <= PMS_STRAP_RESET;
			st_r.pullup_en <= PMS_CTRL_RESET;
			st_r.bresp     <= PMS_RESP_OKAY;
			st_r.rresp     <= PMS_RESP_OKAY;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	// address pins come straight from flops
	// a floated pin relies on the board or the memory to hold its level
	assign upper_code_addr_o       = st_r.addr[15:3];
	assign code_addr_bit2_o        = st_r.addr[2];
	assign code_addr_bit2_oe_o     = st_r.low_oe[2];
	assign code_addr_low_pair_o    = st_r.addr[1:0];
	assign code_addr_low_pair_oe_o = st_r.low_oe[1:0];

	// pull-downs only while strapping, the board must beat them for a 1
	assign strap_pulldown_en_o = {3{st_r.phase == PMS_PH_STRAP}};
	assign code_data_bus_pullup_en_o = st_r.pullup_en;

	// clock selection from the latched straps
	assign clock_drive_strap_o = ext_clk;
	assign clk_freq_48_o       = f48;
	assign clk_freq_reserved_o = f_rsvd;

	// bus handshakes
	// ready is combinational so a request is taken in the cycle it appears
	assign s_axi_awready = ~st_r.aw_got & ~st_r.bvalid;
	assign s_axi_wready  = ~st_r.w_got & ~st_r.bvalid;
	assign s_axi_bvalid  = st_r.bvalid;
	assign s_axi_bresp   = st_r.bresp;
	assign s_axi_arready = ~st_r.rvalid;
	assign s_axi_rvalid  = st_r.rvalid;
	assign s_axi_rdata   = st_r.rdata;
	assign s_axi_rresp   = st_r.rresp;

endmodule

`default_nettype wire

// ---- pms_sva.sv ----
// assertions on the strap latch pins and clock selection
// bound to pms_strap_latch; one clock domain
`timescale 1ns/1ps
`default_nettype none

module pms_sva (
	input wire logic        clk_i, rst_n_i, chip_reset_n_i,
	input wire logic        idle_flag_i, sleep_flag_i, second_interrupt_input_i,
	input wire logic [15:0] cpu_addr_i,
	input wire logic [12:0] upper_code_addr_o,
	input wire logic        code_addr_bit2_o, code_addr_bit2_oe_o,
	input wire logic [1:0]  code_addr_low_pair_o, code_addr_low_pair_oe_o,
	input wire logic [2:0]  strap_pulldown_en_o,
	input wire logic        clock_drive_strap_o, clk_freq_48_o, clk_freq_reserved_o
);
	// float condition and the three low enables
	wire logic fc = idle_flag_i & sleep_flag_i & !second_interrupt_input_i;
	wire logic [2:0] oe = {code_addr_bit2_oe_o, code_addr_low_pair_oe_o};
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////
	a_upper_follow:
		assert property ($past(rst_n_i) |-> upper_code_addr_o == $past(cpu_addr_i[15:3]))
		else $error("upper address lag wrong");
	a_strap_float:
		assert property ((!chip_reset_n_i)[*4] |-> oe == 3'h0)
		else $error("strap pin driven in reset");
	a_pull_on:
		assert property ((!chip_reset_n_i)[*4] |-> strap_pulldown_en_o == 3'h7)
		else $error("pull-down off in reset");
	a_pull_off:
		assert property ((chip_reset_n_i)[*4] |-> strap_pulldown_en_o == 3'h0)
		else $error("pull-down left on");
	a_bit2_float:
		assert property ((chip_reset_n_i)[*4] |->
			code_addr_bit2_oe_o == !(clock_drive_strap_o && $past(fc)))
		else $error("bit two enable wrong");
	a_low_drive:
		assert property ((chip_reset_n_i)[*4] ##0 !$past(fc) |-> code_addr_low_pair_oe_o == 2'h3)
		else $error("low pair not driven");
	a_low_addr:
		assert property ((chip_reset_n_i)[*4] |-> ({code_addr_bit2_o,
			code_addr_low_pair_o} & oe) == ($past(cpu_addr_i[2:0]) & oe))
		else $error("low address wrong");
	a_sel_decode:
		assert property (clk_freq_48_o |-> clock_drive_strap_o && !clk_freq_reserved_o)
		else $error("clock decode wrong");
	a_strap_hold:
		assert property ((chip_reset_n_i)[*4] |-> $stable(clock_drive_strap_o))
		else $error("strap moved after release");
	// main scenarios reached
	c_float: cover property ((chip_reset_n_i)[*4] ##1 !code_addr_bit2_oe_o);
	c_f48: cover property (clk_freq_48_o);
	c_rsv: cover property (clk_freq_reserved_o);
endmodule

bind pms_strap_latch pms_sva u_sva (.*);

`default_nettype wire

// ---- pms_board.sv ----
// board strap resistors and released address lines
// assumes pins resolve as driver, then strap, then pull-down
`timescale 1ns/1ps
`default_nettype none

module pms_board (
	input  wire logic       clk_i,
	input  wire logic       chip_reset_n_i,
	input  wire logic [2:0] strap_i, pd_i, oe_i, o_i,
	output logic      [2:0] pin_o
);
	logic [2:0] last_r;
	// undriven lines flip each cycle so a stale level never passes
	always_ff @(posedge clk_i) last_r <= pin_o;
	// board straps hold only while the chip is held in reset
	always_comb
	begin
		for (int k = 0; k < 3; k++)
			pin_o[k] = oe_i[k] ? o_i[k] : !chip_reset_n_i ? strap_i[k] :
				pd_i[k] ? 1'b0 : ~last_r[k];
	end
endmodule

`default_nettype wire

// ---- tb_program_memory_address_strap_latch.sv ----
// self-checking bench for the strap latch
// assumes pms_pkg and the board model are compiled first
`timescale 1ns/1ps
`default_nettype none

module tb_program_memory_address_strap_latch;
	import pms_pkg::*;
	logic ck = 0, rn = 0, cn = 0, idl = 0, slp = 0, irq = 0, aw = 0, w = 0, ar = 0;
	logic [15:0] ca = 16'h0;
	logic [2:0] st = 3'h0;
	logic [3:0] aa = 4'h0, ra = 4'h0;
	logic [3:0] ws = 4'hf;
	logic [31:0] wd = 32'h0;
	wire logic [2:0] oe, o, pd, pin;
	wire logic [12:0] up;
	wire logic pu, cd, f48, rsv, awr, wrr, bv, arr, rv;
	wire logic [1:0] bre, rre;
	wire logic [31:0] rd;
	int err_count = 0, samples_checked = 0;
	// {strap, idle int sleep, oe, drive f48 reserved}
	logic [11:0] rows [8] = '{12'h178, 12'hf46, 12'hb55, 12'h569,
		12'hffe, 12'h760, 12'hf3e, 12'h87c};
	////////////////////////////////////////
	initial forever #10 ck = ~ck;
	pms_strap_latch dut (.clk_i(ck), .rst_n_i(rn), .chip_reset_n_i(cn), .cpu_addr_i(ca),
		.idle_flag_i(idl), .sleep_flag_i(slp), .second_interrupt_input_i(irq),
		.upper_code_addr_o(up), .code_addr_bit2_i(pin[2]), .code_addr_bit2_o(o[2]),
		.code_addr_bit2_oe_o(oe[2]), .code_addr_low_pair_i(pin[1:0]),
		.code_addr_low_pair_o(o[1:0]), .code_addr_low_pair_oe_o(oe[1:0]),
		.strap_pulldown_en_o(pd), .code_data_bus_pullup_en_o(pu),
		.clock_drive_strap_o(cd), .clk_freq_48_o(f48), .clk_freq_reserved_o(rsv),
		.s_axi_awvalid(aw), .s_axi_awready(awr), .s_axi_awaddr(aa), .s_axi_wvalid(w),
		.s_axi_wready(wrr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv),
		.s_axi_bready(1'b1), .s_axi_bresp(bre), .s_axi_arvalid(ar), .s_axi_arready(arr),
		.s_axi_araddr(ra), .s_axi_rvalid(rv), .s_axi_rready(1'b1), .s_axi_rdata(rd),
		.s_axi_rresp(rre));
	pms_board board (.clk_i(ck), .chip_reset_n_i(cn), .strap_i(st), .pd_i(pd),
		.oe_i(oe), .o_i(o), .pin_o(pin));
	////////////////////////////////////////
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			err_count++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	// ready held high; each channel drops valid at its own handshake
	task wrt(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
		aw <= 1'b1;
		w  <= 1'b1;
		aa <= a;
		wd <= d;
		do
		begin
			@(posedge ck);
			if (awr)
				aw <= 1'b0;
			if (wrr)
				w <= 1'b0;
		end
		while (!bv);
		chk("bresp", e, bre);
	endtask
	task rdc(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
		ar <= 1'b1;
		ra <= a;
		do
		begin
			@(posedge ck);
			if (arr)
				ar <= 1'b0;
		end
		while (!rv);
		chk("rresp", e, rre);
		if (e == PMS_RESP_OKAY) chk("rdata", d, rd);
	endtask
	task close_out();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// watchdog well beyond the hundred and fifty or so cycles needed
	initial
	begin
		#100us;
		err_count++;
		close_out();
	end
	////////////////////////////////////////
	initial
	begin
		repeat (2) @(posedge ck);
		rn <= 1'b1;
		foreach (rows[i])
		begin
			@(posedge ck) cn <= 1'b0;
			st <= rows[i][11:9];
			{idl, irq, slp} <= rows[i][8:6];
			ca <= {rows[i], 4'h5};
			repeat (5) @(posedge ck);
			chk("pd_on", 3'h7, pd);
			cn <= 1'b1;
			repeat (6) @(posedge ck);
			chk("oe", rows[i][5:3], oe);
			chk("sel", rows[i][2:0], {cd, f48, rsv});
			chk("upper", ca[15:3], up);
			chk("low", ca[2:0] & oe, o & oe);
			chk("pd_off", 3'h0, pd);
			rdc(PMS_STATUS_OFS, {rows[i][8:6] == 3'h5, 1'b0, rows[i][0], rows[i][1],
				rows[i][2], rows[i][11:9]}, PMS_RESP_OKAY);
			$display("row %0d done", i);
		end
		// data pull-ups under software control, bad addresses refused
		wrt(PMS_CTRL_OFS, 32'h0, PMS_RESP_OKAY);
		chk("pullup", 1'b0, pu);
		rdc(PMS_CTRL_OFS, 32'h0, PMS_RESP_OKAY);
		// without its low byte lane a write leaves the enable alone
		ws <= 4'he;
		wrt(PMS_CTRL_OFS, 32'h1, PMS_RESP_OKAY);
		ws <= 4'hf;
		chk("strb_pu", 1'b0, pu);
		// status is read-only: a write is answered and changes nothing
		wrt(PMS_STATUS_OFS, 32'hffff_ffff, PMS_RESP_OKAY);
		wrt(4'h8, 32'h1, PMS_RESP_SLVERR);
		chk("slverr_pu", 1'b0, pu);
		rdc(4'hc, 32'h0, PMS_RESP_SLVERR);
		$display("register test done");
		// mid-run reset restores pull-ups and strap phase
		@(posedge ck) rn <= 1'b0;
		cn <= 1'b0;
		@(posedge ck) chk("rst_oe", 3'h0, oe);
		chk("rst_pu", 1'b1, pu);
		// chip reset outlasts the logic reset so the straps are sampled again
		rn <= 1'b1;
		repeat (4) @(posedge ck);
		cn <= 1'b1;
		{idl, irq, slp} <= 3'h5;
		repeat (6) @(posedge ck);
		chk("rst_sel", 3'h4, {cd, f48, rsv});
		chk("float", 3'h3, oe);
		irq <= 1'b1;
		repeat (2) @(posedge ck);
		chk("wake", 3'h7, oe);
		$display("reset test done");
		close_out();
	end
endmodule

`default_nettype wire
